// *** src/channel_event_and_slot_map.v ***
// Channel event word builder, per-channel masks, time slot map and
// transmit abort sequencing. Assumes events arrive one per cycle from
// the channel engines, and highway slot/bit positions are synchronous.
//
// Notes on behaviour
// - V.110 rx fault on buffer loss or three bad sync frames.
// - V.110 rx fault on fast abort, short paused descriptor, long abort.
// - V.110 tx fault on bad last descriptor bits.
// - Octet mode rx fault only on short descriptor or fast abort.
// - Flagged/ratefree rx fault with frame done on listed errors.
// - HDLC/flagged rx overflow when frames or notices are dropped.
// - Non-V.110 tx overflow aborts frame with mode pattern; a bus fault only raises a fault.
// - After abort send fill, then refetch and finish the frame.
// - V.110 rx overflow when notices are dropped.
// - V.110 tx overflow sends three corrupted frames then resumes.
// - Octet mode rx overflow when data is dropped.
// - Per-channel masks gate event bits by direction.
// - Slot map fetched once per action pulse with setup or init.
// - Map ties 32 slots to channels, separate tx and rx numbers.
// - A channel may use different rx and tx slots.
// - Non-octet modes keep mask-one bits, drop or tristate others.
// - Octet mode delivers masked rx bits as ones, tristates tx.
// - Subchanneling gives rates from 8 kbit/s to 2.048 Mbit/s.
// - Tx inhibit tristates slot and holds the data.
// - Rx inhibit ignores the slot data.
// - Masking acts per bit; all masked suppresses the event.
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "chan_event_regs.vh"
module channel_event_and_slot_map (
    input  wire        ref_clk_i,     // System clock, 100 MHz.
    input  wire        rst_i,         // Synchronous reset, high.
    input  wire        hsel_i,        // AHB select.
    input  wire [11:0] haddr_i,       // AHB address.
    input  wire [1:0]  htrans_i,      // AHB transfer type.
    input  wire        hwrite_i,      // AHB write.
    input  wire [2:0]  hsize_i,       // AHB size.
    input  wire [31:0] hwdata_i,      // AHB write data.
    input  wire        hready_i,      // AHB bus ready.
    output reg  [31:0] hrdata_o,      // AHB read data.
    output wire        hreadyout_o,   // AHB slave ready.
    output wire        hresp_o,       // AHB response.
    input  wire        ev_valid_i,    // Event strobe.
    input  wire        ev_dir_i,      // Event direction, 1 receive.
    input  wire [4:0]  ev_chan_i,     // Event channel.
    input  wire [2:0]  ev_mode_i,     // Channel mode.
    input  wire [10:0] ev_cause_i,    // Event causes.
    output reg         event_valid_o, // Event word strobe.
    output reg  [31:0] event_word_o,  // Channel event word.
    input  wire        mem_ok_i,      // Shared memory reachable.
    input  wire        v110_frame_i,  // Tx 10-octet frame boundary.
    output reg         tx_fill_o,     // Sending interframe fill.
    output reg         tx_corrupt_o,  // Sending corrupted frames.
    output reg  [15:0] abort_pat_o,   // Abort pattern, LSB first.
    output reg  [4:0]  abort_len_o,   // Abort pattern length.
    output reg         abort_o,       // Abort pattern start pulse.
    output reg         refetch_o,     // Refetch/resume pulse.
    input  wire [4:0]  hw_slot_i,     // Highway slot number.
    input  wire [2:0]  hw_bit_i,      // Bit within slot.
    input  wire        hw_bit_en_i,   // Bit strobe.
    input  wire        hw_rxd_i,      // Highway receive bit.
    input  wire        octet_mode_i,  // Channel in octet mode.
    output reg         rx_bit_vld_o,  // Received bit for a channel.
    output reg         rx_bit_o,      // Received bit value.
    output reg  [4:0]  rx_chan_o,     // Receive channel.
    output wire [4:0]  tx_chan_o,     // Channel asked for a bit.
    output wire        tx_take_o,     // Tx bit consumed this strobe.
    input  wire        tx_bit_i,      // Tx bit from channel.
    output reg         hw_txd_o,      // Highway transmit bit.
    output reg         hw_txd_oe_o    // Highway transmit enable.
);

// ****************************************
// Storage
// ****************************************
reg  [31:0] slot_assignment_word [0:31]; // Software-written map.
reg  [31:0] act_map [0:31];              // Map in use on the highway.
reg  [7:0]  chan_mask [0:31];
reg  [1:0]  sync_cnt [0:31];
reg  [1:0]  abt_cnt [0:31];
reg  [31:0] channel_event_word;
reg  [11:0] dp_addr;
reg         dp_write;
reg  [1:0]  state;
reg  [1:0]  corrupt_cnt;
reg         fetch_req;
integer     i;

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_FILL = 2'h1;
localparam [1:0] ST_CORR = 2'h2;

// ****************************************
// AHB-Lite slave
// ****************************************
// Zero wait states, so the answer is always OKAY and ready.
assign hreadyout_o = 1'b1;
assign hresp_o     = 1'b0;

wire addr_ph = hsel_i & hready_i & htrans_i[1];
wire in_mask = (haddr_i[11:7] == 5'h01);
wire in_slot = (haddr_i[11:7] == 5'h02);

// Capture address phase and prepare read data for the data phase.
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        dp_addr  <= 12'h000;
        dp_write <= 1'b0;
        hrdata_o <= `RST_WORD;
    end else begin
        dp_write <= addr_ph & hwrite_i;
        dp_addr  <= haddr_i;
        if (addr_ph & ~hwrite_i) begin
            if (in_mask)
                hrdata_o <= {24'h000000, chan_mask[haddr_i[6:2]]};
            else if (in_slot)
                hrdata_o <= slot_assignment_word[haddr_i[6:2]];
            else if (haddr_i == `OFS_EVENT)
                hrdata_o <= channel_event_word;
            else if (haddr_i == `OFS_TXSTATE)
                hrdata_o <= {28'h0000000, corrupt_cnt, state};
            else
                hrdata_o <= `RST_WORD;
        end
    end
end

wire wr_mask   = dp_write & (dp_addr[11:7] == 5'h01);
wire wr_slot   = dp_write & (dp_addr[11:7] == 5'h02);
wire wr_action = dp_write & (dp_addr == `OFS_ACTION);

// Register writes; unmapped writes are dropped.
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        for (i = 0; i < 32; i = i + 1) begin
            chan_mask[i]            <= `RST_MASK;
            slot_assignment_word[i] <= `RST_WORD;
        end
        fetch_req <= 1'b0;
    end else begin
        if (wr_mask)
            chan_mask[dp_addr[6:2]] <= hwdata_i[7:0];
        if (wr_slot)
            slot_assignment_word[dp_addr[6:2]] <= hwdata_i & 32'h3FFF3FFF;
        fetch_req <= wr_action &
                     (hwdata_i[`ACT_SETUP] | hwdata_i[`ACT_INIT]);
    end
end

// ****************************************
// Slot map fetch
// ****************************************
// The active map changes only on an action pulse, so highway lookups
// never see a half-written table while software edits the map.
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        for (i = 0; i < 32; i = i + 1)
            act_map[i] <= `RST_WORD;
    end else if (fetch_req) begin
        for (i = 0; i < 32; i = i + 1)
            act_map[i] <= slot_assignment_word[i];
    end
end

// ****************************************
// Event word builder
// ****************************************
wire [7:0] msk    = chan_mask[ev_chan_i];
wire       rb_los = ev_cause_i[0];
wire       bad_sy = ev_cause_i[1];
wire       f_abt  = ev_cause_i[2];
wire       sh_dsc = ev_cause_i[3];
wire       abt_fr = ev_cause_i[4];
wire       odd_ln = ev_cause_i[5];
wire       fr_end = ev_cause_i[6];
wire       dropd  = ev_cause_i[7];
wire       fill_c = ev_cause_i[8];
wire       shortf = ev_cause_i[9];
wire       v_tick = ev_cause_i[10];
// Transmit direction reuses the low cause bits.
wire       t_hold = ev_cause_i[0];
wire       t_last = ev_cause_i[1];
wire       t_zero = ev_cause_i[2];
wire       t_undr = ev_cause_i[3];
wire       t_ldsc = ev_cause_i[5];
wire       t_err  = ev_cause_i[7];
wire       is_v   = (ev_mode_i == `MODE_V110);
wire       sy_hit = v_tick & bad_sy & (sync_cnt[ev_chan_i] == 2'h2);
wire       ab_hit = v_tick & abt_fr & (abt_cnt[ev_chan_i] == 2'h2);

reg  [4:0] raw; // Frame, fill, short, fault, overflow before masking.
reg  [4:0] gate;

// Per-mode cause decode.
always @* begin
    raw = 5'h00;
    if (ev_dir_i) begin
        case (ev_mode_i)
            `MODE_V110: begin
                raw[1] = rb_los | sy_hit;
                raw[1] = raw[1] | f_abt | sh_dsc | ab_hit;
                raw[0] = dropd;
            end
            `MODE_OCTET: begin
                raw[1] = sh_dsc | f_abt;
                raw[0] = dropd;
            end
            `MODE_FLAG, `MODE_RFREE, `MODE_HDLC: begin
                raw[1] = odd_ln | rb_los | sh_dsc | f_abt;
                raw[4] = fr_end | raw[1];
                raw[3] = fill_c;
                raw[2] = shortf;
                raw[0] = dropd;
            end
            default: raw = 5'h00;
        endcase
    end else begin
        if (is_v)
            raw[1] = t_ldsc & (t_hold | t_last | (~t_last & t_zero));
        else begin
            raw[1] = t_err;
            raw[4] = fr_end;
        end
        raw[0] = t_undr;
    end
end

// Direction-dependent mask gating; fault and overflow share one fault mask bit.
always @* begin
    if (ev_dir_i) begin
        gate[4] = raw[4] & ~msk[`M_RXFRAME];
        gate[3] = raw[3] & ~msk[`M_FILL];
        gate[2] = raw[2] & ~msk[`M_SHORT];
        gate[1] = raw[1] & ~msk[`M_RXFAULT];
        gate[0] = raw[0] & ~msk[`M_RXFAULT];
    end else begin
        gate[4] = raw[4] & ~msk[`M_TXFRAME];
        gate[3] = 1'b0;
        gate[2] = 1'b0;
        gate[1] = raw[1] & ~msk[`M_TXFAULT];
        gate[0] = raw[0] & ~msk[`M_TXFAULT];
    end
end

// Publish the word; an event whose bits are all masked disappears.
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        event_valid_o      <= 1'b0;
        event_word_o       <= `RST_WORD;
        channel_event_word <= `RST_WORD;
    end else begin
        event_valid_o <= ev_valid_i & (|gate);
        if (ev_valid_i & (|gate)) begin
            event_word_o       <= {19'h00000, gate, 2'h0, ev_dir_i, ev_chan_i};
            channel_event_word <= {19'h00000, gate, 2'h0, ev_dir_i, ev_chan_i};
        end
    end
end

// Consecutive-frame counters for loss of sync and long receive abort.
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        for (i = 0; i < 32; i = i + 1) begin
            sync_cnt[i] <= 2'h0;
            abt_cnt[i]  <= 2'h0;
        end
    end else if (ev_valid_i & ev_dir_i & is_v & v_tick) begin
        if (~bad_sy)
            sync_cnt[ev_chan_i] <= 2'h0;
        else if (sync_cnt[ev_chan_i] != `SYNC_LOSS_CNT)
            sync_cnt[ev_chan_i] <= sync_cnt[ev_chan_i] + 2'h1;
        if (~abt_fr)
            abt_cnt[ev_chan_i] <= 2'h0;
        else if (abt_cnt[ev_chan_i] != `SYNC_LOSS_CNT)
            abt_cnt[ev_chan_i] <= abt_cnt[ev_chan_i] + 2'h1;
    end
end

// ****************************************
// Transmit abort sequencer
// ****************************************
// One abort is handled at a time; a second underrun during recovery
// is ignored, as the frame is already aborted.
wire tx_hit = ev_valid_i & ~ev_dir_i & t_undr;

always @(posedge ref_clk_i) begin
    if (rst_i) begin
        state        <= ST_IDLE;
        corrupt_cnt  <= 2'h0;
        tx_fill_o    <= 1'b0;
        tx_corrupt_o <= 1'b0;
        abort_o      <= 1'b0;
        refetch_o    <= 1'b0;
        abort_pat_o  <= 16'h0000;
        abort_len_o  <= 5'h00;
    end else begin
        abort_o   <= 1'b0;
        refetch_o <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (tx_hit & is_v) begin
                    state        <= ST_CORR;
                    corrupt_cnt  <= 2'h0;
                    tx_corrupt_o <= 1'b1;
                end else if (tx_hit) begin
                    state     <= ST_FILL;
                    abort_o   <= 1'b1;
                    tx_fill_o <= 1'b1;
                    case (ev_mode_i)
                        `MODE_FLAG: begin
                            abort_pat_o <= 16'h0000;
                            abort_len_o <= 5'h02;
                        end
                        `MODE_RFREE: begin
                            abort_pat_o <= 16'h0000;
                            abort_len_o <= 5'h04;
                        end
                        default: begin
                            abort_pat_o <= 16'hFFFE;
                            abort_len_o <= 5'h0F;
                        end
                    endcase
                end
            end
            ST_FILL: begin
                if (mem_ok_i) begin
                    state     <= ST_IDLE;
                    tx_fill_o <= 1'b0;
                    refetch_o <= 1'b1;
                end
            end
            ST_CORR: begin
                if (v110_frame_i) begin
                    if (corrupt_cnt == `CORRUPT_FRAMES - 2'h1) begin
                        state        <= ST_IDLE;
                        tx_corrupt_o <= 1'b0;
                        refetch_o    <= 1'b1;
                    end else
                        corrupt_cnt <= corrupt_cnt + 2'h1;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

// ****************************************
// Highway slot mapping
// ****************************************
// Each slot carries its own rx and tx channel, so one channel can own
// any mix of slots, and the fill mask picks 1 to 8 bits per slot,
// which spans 8 kbit/s to 2.048 Mbit/s per channel.
wire [31:0] cur   = act_map[hw_slot_i];
wire [4:0]  rx_ch = cur[12:8];
wire [4:0]  tx_ch = cur[28:24];
wire        rx_fm = cur[3'h7 - hw_bit_i];
wire        tx_fm = cur[5'h17 - {2'h0, hw_bit_i}];
wire        tx_ok = hw_bit_en_i & ~cur[`SL_TXINH] & tx_fm;

// Inhibited or masked tx bits are not taken, so data waits.
assign tx_chan_o = tx_ch;
assign tx_take_o = tx_ok;

// Receive delivery and transmit drive per bit strobe.
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        rx_bit_vld_o <= 1'b0;
        rx_bit_o     <= 1'b1;
        rx_chan_o    <= 5'h00;
        hw_txd_o     <= 1'b1;
        hw_txd_oe_o  <= 1'b0;
    end else begin
        rx_chan_o <= rx_ch;
        if (hw_bit_en_i & ~cur[`SL_RXINH]) begin
            if (octet_mode_i) begin
                rx_bit_vld_o <= 1'b1;
                rx_bit_o     <= rx_fm ? hw_rxd_i : 1'b1;
            end else begin
                rx_bit_vld_o <= rx_fm;
                rx_bit_o     <= hw_rxd_i;
            end
        end else
            rx_bit_vld_o <= 1'b0;
        if (hw_bit_en_i) begin
            hw_txd_oe_o <= tx_ok;
            hw_txd_o    <= tx_ok ? tx_bit_i : 1'b1;
        end
    end
end

endmodule // channel_event_and_slot_map

// *** src/chan_event_regs.vh ***
// Constants for the channel event and slot map block.
// Assumes a 32-bit AHB-Lite register bus and 32 channels.
`ifndef CHAN_EVENT_REGS_VH
`define CHAN_EVENT_REGS_VH
// Register byte offsets.
`define OFS_ACTION     12'h000
`define OFS_EVENT      12'h004
`define OFS_TXSTATE    12'h008
`define OFS_MASK_BASE  12'h080
`define OFS_SLOT_BASE  12'h100
// Action word fields.
`define ACT_SETUP      0
`define ACT_INIT       1
// Event word fields.
`define EV_FRAME       12
`define EV_FILL        11
`define EV_SHORT       10
`define EV_FAULT       9
`define EV_OVER        8
`define EV_DIR         5
// Mask byte fields, a one suppresses the bit.
`define M_SHORT        6
`define M_FILL         5
`define M_TXFAULT      3
`define M_RXFAULT      2
`define M_RXFRAME      1
`define M_TXFRAME      0
// Slot word fields.
`define SL_TXINH       29
`define SL_RXINH       13
// Channel modes.
`define MODE_HDLC      3'h0
`define MODE_V110      3'h1
`define MODE_OCTET     3'h2
`define MODE_FLAG      3'h3
`define MODE_RFREE     3'h4
// Counts.
`define SYNC_LOSS_CNT  2'h3
`define CORRUPT_FRAMES 2'h3
// Reset values.
`define RST_WORD       32'h00000000
`define RST_MASK       8'h00
`endif

// *** bench/ce_props_properties.sv ***
// Port checks for the channel event block.
// Assumes one clock and a synchronous high reset.
`timescale 1ns/1ps
module ce_props (
    input wire        ref_clk_i,     // Clock.
    input wire        rst_i,         // Reset.
    input wire        ev_valid_i,    // Event.
    input wire        ev_dir_i,      // Direction.
    input wire [4:0]  ev_chan_i,     // Channel.
    input wire [2:0]  ev_mode_i,     // Mode.
    input wire [10:0] ev_cause_i,    // Causes.
    input wire        event_valid_o, // Word strobe.
    input wire [31:0] event_word_o,  // Word.
    input wire        mem_ok_i,      // Memory up.
    input wire        tx_fill_o,     // Fill.
    input wire        abort_o,       // Abort.
    input wire [15:0] abort_pat_o,   // Pattern.
    input wire [4:0]  abort_len_o,   // Length.
    input wire        refetch_o,     // Refetch.
    input wire        hw_bit_en_i,   // Bit strobe.
    input wire        rx_bit_vld_o,  // Rx valid.
    input wire        hw_txd_o,      // Tx line.
    input wire        hw_txd_oe_o,   // Tx enable.
    input wire        tx_take_o      // Tx taken.
);
    // ********************
    // Assertions
    // ********************
    // One clock; reset disables all checks.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_event_cause: assert property (event_valid_o |-> $past(ev_valid_i))
        else $error("word without event");
    a_event_source: assert property (event_valid_o |->
        event_word_o[5:0] == {$past(ev_dir_i), $past(ev_chan_i)})
        else $error("wrong channel or direction");
    a_tx_bits_only: assert property (event_valid_o && !event_word_o[5] |->
        event_word_o[11:10] == 2'b00)
        else $error("tx event has rx bits");
    a_event_shape: assert property (event_valid_o |-> (event_word_o[12:8] != 5'h00)
        && (event_word_o[31:13] == 19'h0) && (event_word_o[7:6] == 2'b00))
        else $error("bad event word");
    a_octet_no_fault: assert property (ev_valid_i && ev_dir_i && ev_mode_i == 3'h2
        && ev_cause_i == 11'h001 |=> !event_valid_o)
        else $error("octet loss raised event");
    a_abort_shape: assert property (abort_o |-> tx_fill_o &&
        ((abort_len_o == 5'd15 && abort_pat_o[14:0] == 15'h7FFE)
        || (abort_len_o == 5'd2 && abort_pat_o[1:0] == 2'b00)
        || (abort_len_o == 5'd4 && abort_pat_o[3:0] == 4'h0)))
        else $error("bad abort pattern");
    a_fill_release: assert property (tx_fill_o && !abort_o && mem_ok_i |=>
        refetch_o && !tx_fill_o)
        else $error("fill without refetch");
    a_fill_hold: assert property (tx_fill_o && !mem_ok_i |=> tx_fill_o)
        else $error("fill ended early");
    a_rx_strobe: assert property (rx_bit_vld_o |-> $past(hw_bit_en_i))
        else $error("rx bit without strobe");
    a_oe_strobe: assert property (!$past(hw_bit_en_i) && !$past(rst_i) |->
        $stable(hw_txd_oe_o))
        else $error("enable moved without strobe");
    a_take_strobe: assert property (tx_take_o |-> hw_bit_en_i)
        else $error("take without strobe");
    a_txd_idle: assert property (!hw_txd_oe_o |-> hw_txd_o)
        else $error("undriven line not high");
endmodule // ce_props

bind channel_event_and_slot_map ce_props i_props (.*);

// *** bench/highway_model.sv ***
// Highway partner: one bit strobe a cycle.
// Assumes run_i is high for one 256-bit frame.
`timescale 1ns/1ps
module highway_model (
    input  wire       ref_clk_i, // System clock.
    input  wire       run_i,     // Walk the highway while high.
    output wire [4:0] hw_slot_o, // Current slot.
    output wire [2:0] hw_bit_o,  // Bit within slot.
    output wire       hw_en_o,   // Bit strobe.
    output wire       hw_rxd_o,  // Receive line.
    output wire       tx_bit_o   // Channel transmit bit.
);
    reg [7:0] pos = 8'h00;
    reg       en  = 1'b0;
    // Toggling line: masked bits cannot pass by luck.
    assign {hw_slot_o, hw_bit_o} = pos;
    assign hw_en_o  = en;
    assign hw_rxd_o = pos[0];
    assign tx_bit_o = ~pos[1];
    // Wraps after slot 31, so each run starts a frame.
    always @(posedge ref_clk_i) begin
        en <= run_i;
        if (en)
            pos <= pos + 8'h01;
    end
endmodule // highway_model

// *** bench/tb_top.sv ***
// Self-checking bench for the channel event block.
// Assumes the highway model and the bound checker.
`timescale 1ns/1ps
`include "chan_event_regs.vh"
module tb_top;
    logic        ref_clk_i, rst_i, hsel_i, hwrite_i, ev_valid_i, ev_dir_i, run, mon;
    logic        mem_ok_i, v110_frame_i, octet_mode_i;
    logic [11:0] haddr_i;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i, ev_mode_i;
    logic [31:0] hwdata_i, rd;
    logic [4:0]  ev_chan_i;
    logic [10:0] ev_cause_i;
    wire  [31:0] hrdata_o, event_word_o;
    wire  [15:0] abort_pat_o;
    wire  [4:0]  abort_len_o, rx_chan_o, tx_chan_o, hw_slot_i;
    wire  [2:0]  hw_bit_i;
    wire         hready_i, hreadyout_o, hresp_o, event_valid_o, tx_fill_o, tx_corrupt_o;
    wire         abort_o, refetch_o, hw_bit_en_i, hw_rxd_i, rx_bit_vld_o, rx_bit_o;
    wire         tx_take_o, tx_bit_i, hw_txd_o, hw_txd_oe_o;
    int          failures = 0, check_count = 0, n_rx, n_one, n_oe, n_take;

    assign hready_i = hreadyout_o;
    channel_event_and_slot_map i_dut (.*);
    highway_model i_hw (.ref_clk_i, .run_i(run), .hw_slot_o(hw_slot_i), .hw_bit_o(hw_bit_i),
        .hw_en_o(hw_bit_en_i), .hw_rxd_o(hw_rxd_i), .tx_bit_o(tx_bit_i));

    // ********************
    // Clock, monitor and shared tasks
    // ********************
    // Free-running 100 MHz system clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Counts rx bits of channel 5 and tx takes of channel 7.
    always @(posedge ref_clk_i) begin
        if (mon) begin
            if (rx_bit_vld_o === 1'b1 && rx_chan_o === 5'h05) begin
                n_rx++;
                n_one += int'(rx_bit_o === 1'b1);
            end
            if (hw_txd_oe_o === 1'b1) n_oe++;
            if (tx_take_o === 1'b1 && tx_chan_o === 5'h07) n_take++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One word transfer; each phase waits for hready.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        {hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, 2'h2, a, w};
        @(posedge ref_clk_i);
        while (hready_i !== 1'b1) @(posedge ref_clk_i);
        {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, d};
        @(posedge ref_clk_i);
        while (hready_i !== 1'b1) @(posedge ref_clk_i);
        rd = hrdata_o;
        chk({hreadyout_o, hresp_o}, 32'h2);
    endtask

    // One channel 3 event; f is frame, fill, short, fault, overflow.
    task automatic ev(input logic d, input logic [2:0] m, input logic [10:0] c,
                      input logic [4:0] f);
        {ev_valid_i, ev_dir_i, ev_mode_i, ev_cause_i} <= {1'b1, d, m, c};
        @(posedge ref_clk_i);
        ev_valid_i <= 1'b0;
        #1;
        chk({31'h0, event_valid_o}, {31'h0, |f});
        if (|f) chk(event_word_o, {19'h0, f, 2'b00, d, 5'h03});
    endtask

    // ********************
    // Scenarios
    // ********************
    // Tx underrun, memory down: abort, fill, then refetch.
    task automatic abort_run(input logic [2:0] m, input logic [4:0] n, input logic [15:0] p);
        mem_ok_i <= 1'b0;
        ev(1'b0, m, 11'h008, 5'b00001);
        chk({abort_o, tx_fill_o, 9'h0, abort_len_o, abort_pat_o & ((16'h1 << n) - 16'h1)},
            {2'b11, 9'h0, n, p});
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk({30'h0, refetch_o, tx_fill_o}, 32'h1);
        mem_ok_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        chk({30'h0, refetch_o, tx_fill_o}, 32'h2);
    endtask

    // V.110 underrun: three corrupted frames, then resume.
    task automatic corrupt_run();
        logic seen;
        seen = 1'b0;
        ev(1'b0, `MODE_V110, 11'h008, 5'b00001);
        for (int i = 0; i < 3; i++) begin
            chk({30'h0, tx_corrupt_o, seen}, 32'h2);
            v110_frame_i <= 1'b1;
            @(posedge ref_clk_i);
            #1;
            v110_frame_i <= 1'b0;
            seen = seen | refetch_o;
            @(posedge ref_clk_i);
            #1;
        end
        seen = seen | refetch_o;
        chk({30'h0, tx_corrupt_o, seen}, 32'h1);
    endtask

    // One highway frame: rx bits, ones, drive cycles, bits taken.
    task automatic frame(input int r, input int o, input int e, input int t);
        {n_rx, n_one, n_oe, n_take} = '0;
        mon = 1'b1;
        run <= 1'b1;
        repeat (256) @(posedge ref_clk_i);
        run <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        mon = 1'b0;
        chk(n_rx, r);
        chk(n_one, o);
        chk(n_oe, e);
        chk(n_take, t);
    endtask

    // The run needs under 3000 cycles; allow 20000.
    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        {rst_i, mem_ok_i, hsize_i} = {1'b1, 1'b1, 3'h2};
        {hsel_i, hwrite_i, ev_valid_i, ev_dir_i, run, mon, v110_frame_i, octet_mode_i} = 8'h00;
        {haddr_i, htrans_i, hwdata_i, ev_mode_i, ev_cause_i} = '0;
        ev_chan_i = 5'h03;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        bus(1'b1, `OFS_MASK_BASE + 12'h00C, 32'h64);
        bus(1'b0, `OFS_MASK_BASE + 12'h00C, 32'h0);
        chk(rd, 32'h64);
        bus(1'b1, `OFS_SLOT_BASE + 12'h014, 32'hFFFFFFFF);
        bus(1'b0, `OFS_SLOT_BASE + 12'h014, 32'h0);
        chk(rd, 32'h3FFF3FFF);
        bus(1'b1, 12'h040, 32'hFFFFFFFF);
        bus(1'b0, 12'h040, 32'h0);
        chk(rd, 32'h0);
        ev(1'b1, `MODE_FLAG, 11'h060, 5'b10000);
        ev(1'b1, `MODE_HDLC, 11'h300, 5'b00000);
        ev(1'b1, `MODE_HDLC, 11'h080, 5'b00000);
        ev(1'b0, `MODE_V110, 11'h022, 5'b00010);
        bus(1'b1, `OFS_MASK_BASE + 12'h00C, 32'hB);
        ev(1'b1, `MODE_FLAG, 11'h060, 5'b00010);
        ev(1'b0, `MODE_V110, 11'h022, 5'b00000);
        ev(1'b1, `MODE_HDLC, 11'h300, 5'b01100);
        bus(1'b1, `OFS_EVENT, 32'hFFFFFFFF);
        bus(1'b0, `OFS_EVENT, 32'h0);
        chk(rd, 32'hC23);
        bus(1'b1, `OFS_MASK_BASE + 12'h00C, 32'h0);
        ev(1'b1, `MODE_V110, 11'h001, 5'b00010);
        for (int i = 0; i < 3; i++) ev(1'b1, `MODE_V110, 11'h402, {3'b000, i == 2, 1'b0});
        for (int i = 0; i < 3; i++) ev(1'b1, `MODE_V110, 11'h410, {3'b000, i == 2, 1'b0});
        ev(1'b1, `MODE_V110, 11'h004, 5'b00010);
        ev(1'b1, `MODE_V110, 11'h008, 5'b00010);
        ev(1'b0, `MODE_V110, 11'h021, 5'b00010);
        ev(1'b0, `MODE_V110, 11'h024, 5'b00010);
        ev(1'b1, `MODE_OCTET, 11'h001, 5'b00000);
        ev(1'b1, `MODE_OCTET, 11'h004, 5'b00010);
        ev(1'b1, `MODE_OCTET, 11'h008, 5'b00010);
        ev(1'b1, `MODE_FLAG, 11'h060, 5'b10010);
        ev(1'b1, `MODE_RFREE, 11'h004, 5'b10010);
        ev(1'b1, `MODE_RFREE, 11'h001, 5'b10010);
        ev(1'b1, `MODE_HDLC, 11'h080, 5'b00001);
        ev(1'b1, `MODE_V110, 11'h080, 5'b00001);
        ev(1'b1, `MODE_OCTET, 11'h080, 5'b00001);
        abort_run(`MODE_HDLC, 5'd15, 16'h7FFE);
        abort_run(`MODE_FLAG, 5'd2, 16'h0000);
        abort_run(`MODE_RFREE, 5'd4, 16'h0000);
        corrupt_run();
        bus(1'b1, `OFS_SLOT_BASE + 12'h008, 32'h070F05F0);
        bus(1'b1, `OFS_SLOT_BASE + 12'h00C, 32'h25FF);
        bus(1'b1, `OFS_SLOT_BASE + 12'h010, 32'h27FF0000);
        frame(0, 0, 0, 0);
        bus(1'b1, `OFS_ACTION, 32'h1);
        repeat (4) @(posedge ref_clk_i);
        frame(4, 2, 4, 4);
        octet_mode_i <= 1'b1;
        frame(8, 6, 4, 4);
        octet_mode_i <= 1'b0;
        bus(1'b1, `OFS_SLOT_BASE + 12'h008, 32'h070F05FF);
        frame(4, 2, 4, 4);
        bus(1'b1, `OFS_ACTION, 32'h2);
        repeat (4) @(posedge ref_clk_i);
        frame(8, 4, 4, 4);
        end_of_test();
    end
endmodule // tb_top
